// ==== hw/sar_adc_control.sv ====
// sar converter control with wishbone registers and interrupt
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control
    import sar_adc_pkg::*;
#(
    parameter int unsigned STEP_CYC = STEP_CYCLES
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [WB_AW-1:0] adr_i,
    input  wire logic [WB_DW-1:0] dat_i,
    output logic      [WB_DW-1:0] dat_o,
    output logic                  ack_o,
    input  wire logic             comp_i,
    input  wire logic             stop_mode_i,
    output logic      [RES_W-1:0] dac_code_o,
    output logic                  sample_o,
    output logic                  converter_power_o,
    output logic                  irq_o
);

    // ****************
    // bus request capture
    // ****************
    wb_req_t req;
    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i, adr: adr_i, dat: dat_i};

    logic ack;
    wire  req_seen  = req.cyc && req.stb && !ack;
    wire  wr_fire   = req.cyc && req.stb && req.we && ack && req.sel[0];
    wire  hit_ctrl  = (req.adr == REG_CTRL);
    wire  hit_res   = (req.adr == REG_RESULT);
    wire  hit_stat  = (req.adr == REG_STATUS);
    wire  hit_mask  = (req.adr == REG_MASK);
    wire  wr_ctrl   = wr_fire && hit_ctrl;
    wire  wr_stat   = wr_fire && hit_stat;
    wire  wr_mask   = wr_fire && hit_mask;

    ctrl_t wr_ctrl_val;
    assign wr_ctrl_val = ctrl_t'(req.dat[RES_W-1:0]);

    // ****************
    // control state
    // ****************
    logic              conversion_irq_enable;
    logic              converter_power_select;
    logic              eoc;
    logic [RES_W-1:0]  result_data_reg;
    logic [IRQ_W-1:0]  irq_status;
    logic              abort_mask;

    // RL5 start pulse decode
    wire conversion_start_bit = wr_ctrl && wr_ctrl_val.start;
    wire powered              = converter_power_select && !stop_mode_i;

    // ****************
    // comparator synchroniser
    // ****************
    logic comp_s1;
    logic comp_s2;
    logic comp_s3;
    logic comp_level;
    wire  next_comp_level = (comp_s2 == comp_s3) ? comp_s3 : comp_level;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            comp_s1    <= 1'b0;
            comp_s2    <= 1'b0;
            comp_s3    <= 1'b0;
            comp_level <= 1'b0;
        end else begin
            comp_s1    <= comp_i;
            comp_s2    <= comp_s1;
            comp_s3    <= comp_s2;
            comp_level <= next_comp_level;
        end
    end

    // ****************
    // approximation sequencer
    // ****************
    conv_state_t      state;
    conv_state_t      next_state;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] next_trial;
    logic [2:0]       bit_idx;
    logic [2:0]       next_bit_idx;
    logic             step_tick;

    wire busy       = (state == ST_CONVERT);
    wire start_conv = conversion_start_bit && powered;
    wire last_step  = busy && step_tick && (bit_idx == 3'h0);

    // RL12 step length timer
    step_timer #(
        .STEP_CYCLES (STEP_CYC)
    ) u_step_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (start_conv),
        .run_i     (busy),
        .tick_o    (step_tick)
    );

    // RL1 RL4 trial bit kept when input is at or above trial level
    wire [RES_W-1:0] bit_mask   = RES_W'(1) << bit_idx;
    wire [RES_W-1:0] kept_trial = comp_level ? trial : (trial & ~bit_mask);
    wire [RES_W-1:0] below_mask = bit_mask >> 1;

    // RL9 RL10 RL19 one msb-first pass per start, restart on new start
    always_comb begin
        next_state   = state;
        next_trial   = trial;
        next_bit_idx = bit_idx;
        if (start_conv) begin
            next_state   = ST_CONVERT;
            next_trial   = TRIAL_MSB;
            next_bit_idx = BIT_MSB;
        end else if (!powered) begin
            next_state = ST_IDLE;
        end else if (busy && step_tick) begin
            next_trial = kept_trial | below_mask;
            if (bit_idx == 3'h0) begin
                next_state = ST_IDLE;
            end else begin
                next_bit_idx = bit_idx - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state   <= ST_IDLE;
            trial   <= '0;
            bit_idx <= BIT_MSB;
        end else begin
            state   <= next_state;
            trial   <= next_trial;
            bit_idx <= next_bit_idx;
        end
    end

    assign dac_code_o = trial;
    assign sample_o   = busy;

    // RL2 RL3 final code stored; all kept gives FFh, none kept gives 00h
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_data_reg <= RESULT_RESET;
        end else if (last_step && !start_conv) begin
            result_data_reg <= kept_trial;
        end
    end

    // ****************
    // control register
    // ****************
    // RL5 RL6 RL8 RL17 flag set by completion, cleared only by start
    wire next_eoc = conversion_start_bit ? 1'b0 :
                    (last_step && powered) ? 1'b1 : eoc;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eoc                    <= EOC_RESET;
            conversion_irq_enable  <= 1'b0;
            converter_power_select <= 1'b0;
            abort_mask             <= 1'b0;
        end else begin
            eoc <= next_eoc;
            if (wr_ctrl) begin
                conversion_irq_enable  <= wr_ctrl_val.irq_en;
                // RL16 power select write
                converter_power_select <= wr_ctrl_val.power;
            end else if (wr_mask) begin
                conversion_irq_enable  <= req.dat[IRQ_DONE_BIT];
            end
            if (wr_mask) begin
                abort_mask <= req.dat[IRQ_ABORT_BIT];
            end
        end
    end

    // RL18 converter off in stop mode
    assign converter_power_o = powered;

    // ****************
    // interrupt status
    // ****************
    wire [IRQ_W-1:0] irq_set;
    wire [IRQ_W-1:0] irq_mask;
    wire [IRQ_W-1:0] irq_clr;
    assign irq_set[IRQ_DONE_BIT]  = last_step && powered && !conversion_start_bit;
    assign irq_set[IRQ_ABORT_BIT] = conversion_start_bit && busy;
    assign irq_mask[IRQ_DONE_BIT]  = conversion_irq_enable;
    assign irq_mask[IRQ_ABORT_BIT] = abort_mask;
    // RL8 start removes the pending completion request
    assign irq_clr = (wr_stat ? req.dat[IRQ_W-1:0] : '0) |
                     (conversion_start_bit ? IRQ_W'(1) << IRQ_DONE_BIT : '0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= irq_set | (irq_status & ~irq_clr);
        end
    end

    // RL7 RL18 level request gated by mask, usable as wake source
    assign irq_o = |(irq_status & irq_mask);

    // ****************
    // bus answer
    // ****************
    ctrl_t rd_ctrl;
    assign rd_ctrl = '{irq_en: conversion_irq_enable, eoc: eoc, start: 1'b0,
                       power: converter_power_select, rsv: 4'h0};

    // RL11 start position reads zero
    wire [WB_DW-1:0] rd_mux =
        hit_ctrl ? WB_DW'(rd_ctrl)         :
        hit_res  ? WB_DW'(result_data_reg) :
        hit_stat ? WB_DW'(irq_status)      :
        hit_mask ? WB_DW'(irq_mask)        : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack   <= 1'b0;
            dat_o <= '0;
        end else begin
            ack <= req_seen;
            if (req_seen) begin
                dat_o <= rd_mux;
            end
        end
    end

    assign ack_o = ack;

    // ****************
    // checks
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_start_clears_eoc: assert property (conversion_start_bit |=> !eoc) // RL5
        else $error("start did not clear end of conversion");

    chk_done_sets_eoc: assert property ( // RL6
        last_step && powered && !conversion_start_bit |=> eoc && state == ST_IDLE)
        else $error("completion did not set end of conversion");

    chk_irq_needs_en: assert property ( // RL7
        !conversion_irq_enable && !abort_mask |-> !irq_o)
        else $error("interrupt raised while disabled");

    chk_start_drops_irq: assert property ( // RL8
        conversion_start_bit && !abort_mask |=> !irq_o)
        else $error("start left interrupt pending");

    chk_abort_restart: assert property ( // RL9
        start_conv && busy |=> busy && bit_idx == BIT_MSB && trial == TRIAL_MSB)
        else $error("restart did not begin a fresh conversion");

    chk_single_shot: assert property ( // RL10
        state == ST_IDLE && !start_conv |=> state == ST_IDLE)
        else $error("conversion began without a start");

    chk_start_reads_zero: assert property ( // RL11
        $rose(ack) && !req.we && hit_ctrl |-> dat_o[CTRL_START_BIT] == 1'b0)
        else $error("start bit read back as one");

    chk_conv_busy_len: assert property ( // RL12
        start_conv ##1 (!conversion_start_bit && powered) [*8] |-> busy)
        else $error("conversion ended too early");

    chk_power_off_idle: assert property ( // RL16
        !powered && !start_conv |=> state == ST_IDLE)
        else $error("converter ran while powered off");

    chk_eoc_zero_write: assert property ( // RL17
        eoc && wr_ctrl && !wr_ctrl_val.eoc && !wr_ctrl_val.start |=> eoc)
        else $error("zero write cleared end of conversion");

    chk_msb_first: assert property ( // RL19
        busy && step_tick && bit_idx != 3'h0 && !start_conv && powered
        |=> bit_idx == $past(bit_idx) - 3'h1 && busy)
        else $error("approximation step order broken");

    chk_full_scale: assert property ( // RL2
        last_step && !start_conv && comp_level && trial == 8'hFF |=> result_data_reg == 8'hFF)
        else $error("full scale input did not give all ones");

    chk_zero_scale: assert property ( // RL3
        last_step && !start_conv && !comp_level && trial == 8'h01 |=> result_data_reg == 8'h00)
        else $error("zero input did not give all zeros");

    chk_bit_kept: assert property ( // RL4
        busy && step_tick && powered && !start_conv && comp_level
        |=> (trial & $past(bit_mask)) != '0)
        else $error("trial bit dropped though input at or above level");

    chk_bit_dropped: assert property ( // RL4
        busy && step_tick && powered && !start_conv && !comp_level
        |=> (trial & $past(bit_mask)) == '0)
        else $error("trial bit kept though input below level");

    chk_next_trial: assert property ( // RL19
        busy && step_tick && powered && !start_conv && bit_idx != 3'h0
        |=> (trial & $past(below_mask)) != '0)
        else $error("next trial bit not raised");

    chk_result_steady: assert property ( // RL6
        !(last_step && !start_conv) |=> $stable(result_data_reg))
        else $error("result changed without a completion");

    chk_eoc_only_done: assert property ( // RL6
        !eoc && !last_step |=> !eoc)
        else $error("end of conversion set without completion");

    chk_irq_on_done: assert property ( // RL7
        last_step && powered && !conversion_start_bit && conversion_irq_enable && !wr_fire
        |=> irq_o)
        else $error("enabled completion raised no interrupt");

    chk_stop_idle: assert property ( // RL18
        stop_mode_i |=> !busy)
        else $error("conversion ran in stop mode");

    chk_power_reset: assert property ( // RL16
        $fell(rst_i) |-> !converter_power_select && eoc)
        else $error("power select or flag wrong after reset");

    chk_abort_flag: assert property ( // RL9
        start_conv && busy |=> irq_status[IRQ_ABORT_BIT])
        else $error("abandoned conversion not flagged");

    chk_unpowered_start: assert property ( // RL16
        conversion_start_bit && !powered |=> !busy && !eoc)
        else $error("start while unpowered misbehaved");

    chk_ack_follows: assert property (cyc_i && stb_i && !ack |=> ack)
        else $error("request not answered in one cycle");

    chk_ack_single: assert property (ack |=> !ack)
        else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// ==== hw/sar_adc_pkg.sv ====
// constants, field layouts and types of the sar converter control block
// Functional notes
// RL1: convert the selected input by successive approximation into an 8-bit result register.
// RL2: input at or above the high reference gives FFh, no overflow flag.
// RL3: input at or below the low reference gives 00h.
// RL4: result is monotonic in the input voltage.
// RL5: writing one to the start bit begins conversion and clears end-of-conversion.
// RL6: hardware sets end-of-conversion when a conversion finishes; result then valid.
// RL7: completion raises an interrupt only when the interrupt enable is set.
// RL8: a new start clears end-of-conversion and removes the pending interrupt.
// RL9: a start during a conversion abandons it and begins a fresh one.
// RL10: exactly one conversion per start; no repeating mode exists.
// RL11: start bit is write-only and always reads as zero.
// RL12: conversion lasts 70 us, as with an 8 MHz crystal.
// RL13: software powers the converter on at least one access before starting.
// RL14: software writes start and power-on in separate writes.
// RL15: software selects at most one analog input line at a time.
// RL16: power select bit off at zero, on at one, zero after reset.
// RL17: writing zero to end-of-conversion is ignored; only a start clears it.
// RL18: completion interrupt can wake from wait; converter disabled in stop.
// RL19: one result bit per step, msb first, eight steps, flag after last.
package sar_adc_pkg;

    // ****************
    // data widths
    // ****************
    localparam int unsigned RES_W    = 8;
    localparam int unsigned WB_AW    = 8;
    localparam int unsigned WB_DW    = 32;

    // ****************
    // timing
    // ****************
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned CONV_TIME_NS  = 70000;
    localparam int unsigned SAR_STEPS     = 8;
    localparam int unsigned STEP_CYCLES   = CONV_TIME_NS / (SAR_STEPS * CLK_PERIOD_NS);

    // ****************
    // register byte addresses
    // ****************
    localparam logic [WB_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [WB_AW-1:0] REG_RESULT = 8'h04;
    localparam logic [WB_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [WB_AW-1:0] REG_MASK   = 8'h0C;

    // ****************
    // control register fields and reset values
    // ****************
    localparam int unsigned CTRL_IRQ_EN_BIT = 7;
    localparam int unsigned CTRL_EOC_BIT    = 6;
    localparam int unsigned CTRL_START_BIT  = 5;
    localparam int unsigned CTRL_POWER_BIT  = 4;
    localparam logic        EOC_RESET       = 1'b1;
    localparam logic [RES_W-1:0] RESULT_RESET = 8'h00;
    localparam logic [RES_W-1:0] TRIAL_MSB    = 8'h80;
    localparam logic [2:0]       BIT_MSB      = 3'h7;

    // ****************
    // interrupt status and mask fields
    // ****************
    localparam int unsigned IRQ_W         = 2;
    localparam int unsigned IRQ_DONE_BIT  = 0;
    localparam int unsigned IRQ_ABORT_BIT = 1;

    typedef struct packed {
        logic       irq_en;
        logic       eoc;
        logic       start;
        logic       power;
        logic [3:0] rsv;
    } ctrl_t;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [3:0]       sel;
        logic [WB_AW-1:0] adr;
        logic [WB_DW-1:0] dat;
    } wb_req_t;

    typedef enum logic {
        ST_IDLE,
        ST_CONVERT
    } conv_state_t;

endpackage

// ==== hw/step_timer.sv ====
// step timer giving one enable pulse per approximation step
`timescale 1ns/10ps
`default_nettype none
module step_timer #(
    parameter int unsigned STEP_CYCLES = 175
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic restart_i,
    input  wire logic run_i,
    output logic      tick_o
);
    localparam int unsigned CW = $clog2(STEP_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(STEP_CYCLES - 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    wire           at_last = (count == LAST);

    assign tick_o     = run_i && !restart_i && at_last;
    assign next_count = (restart_i || !run_i || at_last) ? '0 : count + CW'(1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_tick_spacing: assert property (tick_o && run_i |=> !tick_o) // RL12
        else $error("step ticks too close");
endmodule
`default_nettype wire

// ==== sim/analog_source.sv ====
// model of the one selected analog input facing the converter's comparator
`timescale 1ns/10ps
`default_nettype none
module analog_source (
    input  wire logic       clk_i,
    input  wire logic [7:0] dac_code_i,
    input  wire logic       power_i,
    input  wire logic [8:0] level_i,
    output logic            comp_o
);
    logic toggle = 1'b0;

    always @(posedge clk_i) begin
        toggle <= ~toggle;
    end

    // one input line
    // unpowered comparator gives no settled answer
    assign comp_o = power_i ? ({1'b0, dac_code_i} <= level_i) : toggle;
endmodule
`default_nettype wire

// ==== sim/test_sar_adc_control.sv ====
// self-checking bench of the sar converter control block
`timescale 1ns/10ps
`default_nettype none
module test_sar_adc_control;
    import sar_adc_pkg::*;
    localparam int unsigned SC = 8;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    wb_req_t          req;
    logic [WB_DW-1:0] dat_o;
    logic             ack_o;
    logic             comp_i;
    logic             stop_mode_i;
    logic [RES_W-1:0] dac_code_o;
    logic             sample_o;
    logic             converter_power_o;
    logic             irq_o;
    logic [8:0]       level;
    logic [8:0]       lv;
    logic [8:0]       lvls [4] = '{9'h000, 9'h07F, 9'h080, 9'h12C};
    logic [32:0]      notes [$];
    logic [32:0]      note;
    int               seed = 27;
    int               fail_count = 0;
    int               total_checks = 0;

    always #25 clk_i = ~clk_i;

    sar_adc_control #(.STEP_CYC(SC)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(req.cyc), .stb_i(req.stb), .we_i(req.we),
        .sel_i(req.sel), .adr_i(req.adr), .dat_i(req.dat), .dat_o(dat_o), .ack_o(ack_o),
        .comp_i(comp_i), .stop_mode_i(stop_mode_i), .dac_code_o(dac_code_o),
        .sample_o(sample_o), .converter_power_o(converter_power_o), .irq_o(irq_o)
    );

    analog_source i_src (
        .clk_i(clk_i), .dac_code_i(dac_code_o), .power_i(converter_power_o),
        .level_i(level), .comp_o(comp_i)
    );

    task automatic close_out();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bit_is(input logic v, input logic e);
        check({31'h0, v}, {31'h0, e});
    endtask

    // read notes its expected data, write notes a skip
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        notes.push_back({~w, d});
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: w ? d : 32'h0};
        for (n = 0; n < 8; n++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        req <= '0;
        if (n == 8) begin
            fail_count++;
            close_out();
        end
    endtask

    task automatic wait_irq();
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge clk_i);
            if (irq_o === 1'b1) break;
        end
        if (n == 300) begin
            fail_count++;
            close_out();
        end
    endtask

    // ****************
    // read monitor
    // ****************
    always @(posedge clk_i) begin
        if (ack_o === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h0, 32'h1);
            end else begin
                note = notes.pop_front();
                if (note[32]) begin
                    check(dat_o, note[31:0]);
                end
            end
        end
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        req = '0;
        stop_mode_i = 1'b0;
        level = 9'h000;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, REG_CTRL, 32'h40);
        wb(1'b0, REG_RESULT, 32'h0);
        wb(1'b0, REG_STATUS, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        wb(1'b1, REG_CTRL, 32'h90);
        wb(1'b0, REG_CTRL, 32'hD0);
        #1 bit_is(irq_o, 1'b0);
        for (int i = 0; i < 8; i++) begin
            lv = (i < 4) ? lvls[i] : {1'b0, 8'($random(seed))};
            level <= lv;
            wb(1'b1, REG_CTRL, 32'hB0);
            #1 bit_is(irq_o, 1'b0);
            check({24'h0, dac_code_o}, 32'h80);
            bit_is(sample_o, 1'b1);
            wb(1'b0, REG_CTRL, 32'h90);
            wait_irq();
            wb(1'b0, REG_CTRL, 32'hD0);
            wb(1'b0, REG_RESULT, (lv > 9'd255) ? 32'hFF : {23'h0, lv});
            wb(1'b0, REG_STATUS, 32'h1);
        end
        wb(1'b1, REG_CTRL, 32'h30);
        repeat (70) @(posedge clk_i);
        bit_is(irq_o, 1'b0);
        wb(1'b0, REG_CTRL, 32'h50);
        wb(1'b1, REG_MASK, 32'h1);
        #1 bit_is(irq_o, 1'b1);
        wb(1'b1, REG_STATUS, 32'h1);
        #1 bit_is(irq_o, 1'b0);
        wb(1'b1, REG_CTRL, 32'h10);
        wb(1'b0, REG_CTRL, 32'h50);
        level <= 9'h05A;
        wb(1'b1, REG_CTRL, 32'hB0);
        repeat (20) @(posedge clk_i);
        wb(1'b1, REG_CTRL, 32'hB0);
        repeat (55) @(posedge clk_i);
        wb(1'b0, REG_CTRL, 32'h90);
        wait_irq();
        wb(1'b0, REG_RESULT, 32'h5A);
        wb(1'b0, REG_STATUS, 32'h3);
        level <= 9'h010;
        repeat (150) @(posedge clk_i);
        bit_is(sample_o, 1'b0);
        wb(1'b0, REG_RESULT, 32'h5A);
        wb(1'b1, REG_STATUS, 32'h3);
        wb(1'b1, REG_CTRL, 32'h20);
        #1 bit_is(converter_power_o, 1'b0);
        repeat (70) @(posedge clk_i);
        wb(1'b0, REG_CTRL, 32'h00);
        wb(1'b1, REG_CTRL, 32'h10);
        wb(1'b1, REG_CTRL, 32'h30);
        repeat (10) @(posedge clk_i);
        stop_mode_i <= 1'b1;
        @(posedge clk_i);
        #1 bit_is(converter_power_o, 1'b0);
        repeat (70) @(posedge clk_i);
        wb(1'b0, REG_CTRL, 32'h10);
        stop_mode_i <= 1'b0;
        close_out();
    end
endmodule
`default_nettype wire
